// ==== hw/hires_pwm_oversample_irq.sv ====
`timescale 1ns/1ps
`include "hires_pwm_consts.svh"

//***************************************************************
// Behaviour
// - Edge step 250 ps, eightieth of clock
// - Fine phase picks one of sixteen clocks
// - Fine resolution switchable, step size selectable
// - Code 00 gives one trigger per period
// - Codes 01/10/11 give 2/4/8 triggers
// - Trigger spacing is sample count over factor
// - One interrupt per switching period at divide setting 1
// - Divider delays interrupt to count-plus-one periods
// - Divided interrupt also starts general converter
// - Settings 1..15 map to fixed divide counts
// - Counter equal sample count starts conversion
// - Fine edges only A fall, B edges
//***************************************************************
module hires_pwm_oversample_irq (
  // Clock, reset, enable
  input  wire logic                                        core_clk,
  input  wire logic                                        reset_n,
  input  wire logic                                        clk_en,
  // Timing setup
  input  wire logic [`HR_CNT_W-1:0]                        period,
  input  wire logic [`HR_CNT_W-1:0]                        sample_trig,
  input  wire logic [`HR_CNT_W-1:0]                        ev_a_rise,
  input  wire hires_pwm_pkg::edge_cfg_t [`HR_EDGE_N-1:0]   ev_fine,
  input  wire hires_pwm_pkg::hr_ctrl_t                     hr_ctrl,
  // Oversampling and interrupt setup
  input  wire logic [1:0]                                  os_sel,
  input  wire logic [3:0]                                  div_setting,
  input  wire logic                                        int_enable,
  input  wire logic                                        general_purpose_converter_route_enable,
  // Power stage side
  output logic                                             pwm_a,
  output logic                                             pwm_b,
  output logic [`HR_EDGE_N-1:0]                            edge_strobe,
  output logic [`HR_EDGE_N-1:0][`HR_FINE_W-1:0]            edge_fine,
  output logic                                             phase_clock_run,
  // Converters and processor
  output logic                                             error_converter_trigger,
  output logic                                             period_irq,
  output logic                                             general_purpose_converter_start
);

  //*************************************************************
  // Constants and helpers
  //*************************************************************
  // Divide count for a 4-bit setting; 0 means divider off
  function automatic logic [`HR_DIV_W-1:0] div_limit(input logic [3:0] sel);
    logic [`HR_DIV_W-1:0] lim;
    lim = `HR_DIV_RST;
    case (sel)
      4'h1:    lim = `DIV_CNT_S1;
      4'h2:    lim = `DIV_CNT_S2;
      4'h3:    lim = `DIV_CNT_S3;
      4'h4:    lim = `DIV_CNT_S4;
      4'h5:    lim = `DIV_CNT_S5;
      4'h6:    lim = `DIV_CNT_S6;
      4'h7:    lim = `DIV_CNT_S7;
      4'h8:    lim = `DIV_CNT_S8;
      4'h9:    lim = `DIV_CNT_S9;
      4'hA:    lim = `DIV_CNT_S10;
      4'hB:    lim = `DIV_CNT_S11;
      4'hC:    lim = `DIV_CNT_S12;
      4'hD:    lim = `DIV_CNT_S13;
      4'hE:    lim = `DIV_CNT_S14;
      4'hF:    lim = `DIV_CNT_S15;
      default: lim = `HR_DIV_RST;
    endcase
    return lim;
  endfunction

  //*************************************************************
  // State
  //*************************************************************
  hires_pwm_pkg::state_t q;                 // Registered state
  hires_pwm_pkg::state_t d;                 // Next state
  logic                  period_end;        // Last count of period
  logic                  div_fire;          // Divider reached its count
  logic                  hires_on;          // Phase clocks usable
  logic [`HR_FINE_W-1:0] fine_mask;         // Bits kept at this step size
  logic [`HR_EDGE_N-1:0] hit;               // Coarse match per fine edge
  logic [`HR_EDGE_N-1:0][`HR_FINE_W-1:0] fine_eff;  // Fine phase after scaling

  assign period_end = (q.cnt >= period);
  assign div_fire   = period_end && (q.div_sel != 4'h0) && (q.div_cnt >= div_limit(q.div_sel));
  // Without running phase clocks a fine phase would pick a dead clock
  assign hires_on   = hr_ctrl.hires_enable && hr_ctrl.phase_clock_set_enable;
  // Coarser steps drop low fine bits: 250 ps, 500 ps, 1 ns, 2 ns
  assign fine_mask  = 4'(`HR_FINE_FULL << hr_ctrl.fine_step_scale);

  //*************************************************************
  // Per-edge coarse match and fine phase choice
  //*************************************************************
  // Edge 0 is A falling, 1 is B rising, 2 is B falling
  genvar gi;
  generate
    for (gi = 0; gi < `HR_EDGE_N; gi++) begin : g_edge
      // Secondary edges only get fine phase in multi-output mode
      logic allow;
      assign allow        = (gi == 0) ? 1'b1 : hr_ctrl.hires_multi_output_enable;
      assign hit[gi]      = (q.cnt == ev_fine[gi].coarse);
      // Fine value picks one of sixteen phase-shifted clocks
      assign fine_eff[gi] = (hires_on && allow) ? (ev_fine[gi].fine & fine_mask) : `HR_FINE_RST;
    end
  endgenerate

  //*************************************************************
  // Next-state logic
  //*************************************************************
  always_comb begin
    d           = q;
    // Pulses last one cycle
    d.strobe    = '0;
    d.error_converter_trig = 1'b0;
    d.irq       = 1'b0;
    d.adc_start = 1'b0;

    // Period counter
    if (period_end) begin
      d.cnt = `HR_CNT_RST;
    end else begin
      d.cnt = 14'(q.cnt + 14'h0001);
    end

    // Oversampling triggers within the period
    if ((q.os_left != 4'h0) && (q.cnt == q.os_next)) begin
      d.error_converter_trig = 1'b1;
      d.os_next   = 14'(q.os_next + q.os_step);
      d.os_left   = 4'(q.os_left - 4'h1);
    end

    // Load a fresh trigger pattern only at the boundary
    if (period_end) begin
      d.os_shift = os_sel;
      d.os_step  = sample_trig >> os_sel;
      d.os_next  = sample_trig >> os_sel;
      d.os_left  = 4'(4'h1 << os_sel);
    end

    // Period interrupt divider
    if (period_end) begin
      if (div_fire) begin
        d.div_cnt   = `HR_DIV_RST;
        d.irq       = int_enable;
        d.adc_start = general_purpose_converter_route_enable;
      end else begin
        d.div_cnt = 8'(q.div_cnt + 8'h01);
      end
      // A new setting restarts the count cleanly
      d.div_sel = div_setting;
      if (div_setting != q.div_sel) begin
        d.div_cnt = `HR_DIV_RST;
      end
    end

    // Output A: rise coarse only, fall fine-capable
    if (q.cnt == ev_a_rise) begin
      d.pwm_a = 1'b1;
    end
    // Falling match wins when both coincide
    if (hit[0]) begin
      d.pwm_a = 1'b0;
    end

    // Output B: both edges fine-capable
    if (hit[1]) begin
      d.pwm_b = 1'b1;
    end
    if (hit[2]) begin
      d.pwm_b = 1'b0;
    end

    // Fine phase is held from its edge until the next one
    for (int i = 0; i < `HR_EDGE_N; i++) begin
      if (hit[i]) begin
        d.strobe[i] = 1'b1;
        d.fine[i]   = fine_eff[i];
      end
    end
  end

  //*************************************************************
  // State register
  //*************************************************************
  // Clock enable low freezes every bit, pulses included
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      q <= '0;
    end else if (clk_en) begin
      q <= d;
    end
  end

  //*************************************************************
  // Outputs
  //*************************************************************
  assign pwm_a                           = q.pwm_a;
  assign pwm_b                           = q.pwm_b;
  assign edge_strobe                     = q.strobe;
  assign edge_fine                       = q.fine;
  // Phase clocks only run when fine placement is in use
  assign phase_clock_run                 = hires_on;
  assign error_converter_trigger         = q.error_converter_trig;
  assign period_irq                      = q.irq;
  assign general_purpose_converter_start = q.adc_start;

  //*************************************************************
  // Checks
  //*************************************************************
  sequence seq_period_end;
    clk_en && period_end;
  endsequence

  sequence seq_div_fire;
    clk_en && div_fire;
  endsequence

  chk_counter_wraps: assert property (@(posedge core_clk) disable iff (!reset_n)
    seq_period_end |=> (q.cnt == `HR_CNT_RST))
    else $error("period counter did not wrap to zero");

  chk_irq_one_cycle: assert property (@(posedge core_clk) disable iff (!reset_n)
    (period_irq && clk_en) |=> !period_irq)
    else $error("period interrupt longer than one cycle");

  chk_irq_divided: assert property (@(posedge core_clk) disable iff (!reset_n)
    (seq_div_fire ##0 int_enable) |=> period_irq)
    else $error("divider reached count without interrupt");

  chk_adc_routed: assert property (@(posedge core_clk) disable iff (!reset_n)
    $rose(general_purpose_converter_start) |-> $past(clk_en && period_end && (q.div_sel != 4'h0)))
    else $error("converter start outside divider event");

  chk_div_in_range: assert property (@(posedge core_clk) disable iff (!reset_n)
    (q.div_sel != 4'h0) |-> (q.div_cnt <= div_limit(q.div_sel)))
    else $error("divider count beyond selected limit");

  chk_os_budget: assert property (@(posedge core_clk) disable iff (!reset_n)
    q.os_left <= 4'(4'h1 << q.os_shift))
    else $error("more oversampling triggers left than factor");

  chk_os_boundary: assert property (@(posedge core_clk) disable iff (!reset_n)
    (!period_end && clk_en) |=> (q.os_shift == $past(q.os_shift)))
    else $error("oversampling factor changed mid period");

  chk_fine_off: assert property (@(posedge core_clk) disable iff (!reset_n)
    (clk_en && hit[0] && !hires_on) |=> (edge_fine[0] == `HR_FINE_RST) && edge_strobe[0])
    else $error("fine phase used while fine resolution off");

  chk_a_falls: assert property (@(posedge core_clk) disable iff (!reset_n)
    (clk_en && hit[0]) |=> !pwm_a)
    else $error("output A did not fall at its edge");

  chk_single_trig: assert property (@(posedge core_clk) disable iff (!reset_n)
    (clk_en && q.os_shift == `OS_SEL_1X && q.os_left == 4'h1 && q.cnt == q.os_next && !period_end)
      |=> error_converter_trigger && (q.os_left == 4'h0))
    else $error("single trigger mode misbehaved");

  //*************************************************************
  // Trigger and divider checks
  //*************************************************************
  // A pending target reached inside the period
  sequence seq_os_match;
    clk_en && (q.os_left != 4'h0) && (q.cnt == q.os_next);
  endsequence

  chk_trig_at_match: assert property (@(posedge core_clk) disable iff (!reset_n)
    seq_os_match |=> error_converter_trigger)
    else $error("no converter trigger at sample count match");

  chk_no_trig_idle: assert property (@(posedge core_clk) disable iff (!reset_n)
    (clk_en && (q.os_left == 4'h0)) |=> !error_converter_trigger)
    else $error("converter trigger beyond per-period budget");

  chk_div_restart: assert property (@(posedge core_clk) disable iff (!reset_n)
    seq_div_fire |=> (q.div_cnt == `HR_DIV_RST))
    else $error("divider did not restart after firing");

  chk_irq_gated: assert property (@(posedge core_clk) disable iff (!reset_n)
    (clk_en && !int_enable) |=> !period_irq)
    else $error("period interrupt raised while disabled");

  // Pulses hold their level through a frozen cycle: not lost, but stretched if high
  chk_pulse_frozen: assert property (@(posedge core_clk) disable iff (!reset_n)
    !clk_en |=> ($stable(period_irq) && $stable(general_purpose_converter_start)
      && $stable(error_converter_trigger)))
    else $error("pulse output changed while clock enable low");

  //*************************************************************
  // Edge checks
  //*************************************************************
  chk_b_rises: assert property (@(posedge core_clk) disable iff (!reset_n)
    (clk_en && hit[1] && !hit[2]) |=> pwm_b)
    else $error("output B did not rise at its edge");

  chk_b_falls: assert property (@(posedge core_clk) disable iff (!reset_n)
    (clk_en && hit[2]) |=> !pwm_b)
    else $error("output B did not fall at its edge");

  chk_fine_full: assert property (@(posedge core_clk) disable iff (!reset_n)
    (clk_en && hit[0] && hires_on && (hr_ctrl.fine_step_scale == 2'h0))
      |=> (edge_fine[0] == $past(ev_fine[0].fine)))
    else $error("finest step did not pass full fine phase");

  chk_b_fine_gate: assert property (@(posedge core_clk) disable iff (!reset_n)
    (clk_en && hit[1] && !hr_ctrl.hires_multi_output_enable) |=> (edge_fine[1] == `HR_FINE_RST))
    else $error("output B fine phase used without multi-output mode");

endmodule

// ==== hw/hires_pwm_consts.svh ====
`ifndef HIRES_PWM_CONSTS_SVH
`define HIRES_PWM_CONSTS_SVH

// Fine edge timing
`define HR_FINE_STEP_PS   250
`define HR_PHASE_COUNT    16
`define HR_CLK_PERIOD_PS  20000

// Field widths
`define HR_CNT_W          14
`define HR_FINE_W         4
`define HR_DIV_W          8
`define HR_EDGE_N         3

// Oversampling field codes
`define OS_SEL_1X         2'h0
`define OS_SEL_2X         2'h1
`define OS_SEL_4X         2'h2
`define OS_SEL_8X         2'h3

// Interrupt divide counts for settings 1 to 15
`define DIV_CNT_S1        8'h00
`define DIV_CNT_S2        8'h01
`define DIV_CNT_S3        8'h03
`define DIV_CNT_S4        8'h07
`define DIV_CNT_S5        8'h0F
`define DIV_CNT_S6        8'h1F
`define DIV_CNT_S7        8'h2F
`define DIV_CNT_S8        8'h3F
`define DIV_CNT_S9        8'h4F
`define DIV_CNT_S10       8'h5F
`define DIV_CNT_S11       8'h7F
`define DIV_CNT_S12       8'h9F
`define DIV_CNT_S13       8'hBF
`define DIV_CNT_S14       8'hDF
`define DIV_CNT_S15       8'hFF

// Reset values and full fine mask
`define HR_CNT_RST        14'h0000
`define HR_DIV_RST        8'h00
`define HR_FINE_RST       4'h0
`define HR_FINE_FULL      4'hF

`endif

// ==== hw/hires_pwm_pkg.sv ====
`include "hires_pwm_consts.svh"

package hires_pwm_pkg;

  // One fine-capable edge: coarse count above, fine phase below
  typedef struct packed {
    logic [`HR_CNT_W-1:0]  coarse;
    logic [`HR_FINE_W-1:0] fine;
  } edge_cfg_t;

  // Fine resolution controls
  typedef struct packed {
    logic       hires_enable;
    logic       hires_multi_output_enable;
    logic [1:0] fine_step_scale;
    logic       phase_clock_set_enable;
  } hr_ctrl_t;

  // Complete state of the channel
  typedef struct packed {
    logic [`HR_CNT_W-1:0]                   cnt;
    logic [1:0]                             os_shift;
    logic [`HR_CNT_W-1:0]                   os_step;
    logic [`HR_CNT_W-1:0]                   os_next;
    logic [3:0]                             os_left;
    logic [3:0]                             div_sel;
    logic [`HR_DIV_W-1:0]                   div_cnt;
    logic                                   pwm_a;
    logic                                   pwm_b;
    logic [`HR_EDGE_N-1:0]                  strobe;
    logic [`HR_EDGE_N-1:0][`HR_FINE_W-1:0]  fine;
    logic                                   error_converter_trig;
    logic                                   irq;
    logic                                   adc_start;
  } state_t;

endpackage

// ==== dv/conv_model.sv ====
`timescale 1ns/1ps

//***************************************************************
// Converter front end and processor side
//***************************************************************
module conv_model (
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        reset_n,
  // Window restart from the bench
  input  wire logic        clear,
  // Pulses seen from the channel
  input  wire logic        trig,
  input  wire logic        irq,
  input  wire logic        start,
  // Counts within the current window
  output logic [15:0]      trig_n,
  output logic [15:0]      irq_n,
  output logic [15:0]      start_n,
  output logic [15:0]      min_gap
);
  logic [15:0] gap;  // Cycles since the last sample

  // One sample per trigger pulse; gap restarts on clear so a stale
  // trigger from an older mode never sets the spacing
  always_ff @(posedge core_clk) begin
    if (!reset_n || clear) begin
      trig_n  <= 16'h0000;
      irq_n   <= 16'h0000;
      start_n <= 16'h0000;
      min_gap <= 16'hFFFF;
      gap     <= 16'hFFFF;
    end else begin
      trig_n  <= trig_n + {15'h0000, trig};
      irq_n   <= irq_n + {15'h0000, irq};
      start_n <= start_n + {15'h0000, start};
      if (trig) begin
        min_gap <= (gap < min_gap) ? gap : min_gap;
        gap     <= 16'h0001;
      end else if (gap != 16'hFFFF) begin
        gap <= gap + 16'h0001;
      end
    end
  end
endmodule

// ==== dv/tb.sv ====
`timescale 1ns/1ps
`include "hires_pwm_consts.svh"

module tb;
  logic                                      core_clk = 1'b0;
  logic                                      reset_n = 1'b0;
  logic [13:0]                               period = 14'h0063;
  logic [13:0]                               sample_trig = 14'h0028;
  logic [13:0]                               ev_a_rise = 14'h000A;
  hires_pwm_pkg::edge_cfg_t [`HR_EDGE_N-1:0] ev_fine;
  hires_pwm_pkg::hr_ctrl_t                   hr_ctrl = '0;
  logic [1:0]                                os_sel = 2'h0;
  logic [3:0]                                div_setting = 4'h0;
  logic                                      int_enable = 1'b1;
  logic                                      route = 1'b1;
  logic                                      clear = 1'b0;
  logic                                      en = 1'b1;
  logic                                      pwm_a, pwm_b, run_ph, trig, irq, start;
  logic [2:0]                                strobe;
  logic [2:0][3:0]                           efine;
  logic [15:0]                               trig_n, irq_n, start_n, min_gap, hi_a, hi_b, hi_s;
  int                                        mismatches = 0;
  int                                        comparisons = 0;
  int                                        lim[15] = '{1, 2, 4, 8, 16, 32, 48, 64, 80, 96, 128, 160, 192, 224, 256};

  // 50 MHz clock
  always #10 core_clk = ~core_clk;

  hires_pwm_oversample_irq uut (
    .core_clk(core_clk), .reset_n(reset_n), .clk_en(en), .period(period),
    .sample_trig(sample_trig), .ev_a_rise(ev_a_rise), .ev_fine(ev_fine), .hr_ctrl(hr_ctrl),
    .os_sel(os_sel), .div_setting(div_setting), .int_enable(int_enable),
    .general_purpose_converter_route_enable(route), .pwm_a(pwm_a), .pwm_b(pwm_b), .edge_strobe(strobe),
    .edge_fine(efine), .phase_clock_run(run_ph), .error_converter_trigger(trig),
    .period_irq(irq), .general_purpose_converter_start(start));

  conv_model fe (
    .core_clk(core_clk), .reset_n(reset_n), .clear(clear), .trig(trig), .irq(irq),
    .start(start), .trig_n(trig_n), .irq_n(irq_n), .start_n(start_n), .min_gap(min_gap));

  //***************************************************************
  // Helpers
  //***************************************************************
  task automatic run(input int n);
    repeat (n) @(negedge core_clk);
  endtask

  // Restart counting, then count over n rising edges
  task automatic window(input int n);
    clear = 1'b1;
    run(1);
    clear = 1'b0;
    run(n);
  endtask

  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic end_of_test;
    if (mismatches == 0 && comparisons > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  //***************************************************************
  // Scenarios
  //***************************************************************
  initial begin
    ev_fine = {18'h00000, 18'h00000, 18'h00000};
    // Reset for 12 cycles, outputs A, B, trigger and interrupt quiet
    run(12);
    check({12'h000, pwm_a, pwm_b, trig, irq}, 16'h0000);
    reset_n = 1'b1;
    // Oversampling: period of 100 cycles, sample count 40
    for (int k = 0; k < 4; k++) begin
      os_sel = k[1:0];
      run(200);
      window(200);
      check(trig_n, 16'h0002 << k);
      check(min_gap, (k == 0) ? 16'h0064 : (16'h0028 >> k));
    end
    // Edges: A high 11..50, B high 21..30
    ev_fine[0] = {14'h0032, 4'hF};
    ev_fine[1] = {14'h0014, 4'h7};
    ev_fine[2] = {14'h001E, 4'h3};
    hr_ctrl = '{1'b1, 1'b0, 2'h2, 1'b1};
    run(200);
    hi_a = 16'h0000;
    hi_b = 16'h0000;
    hi_s = 16'h0000;
    for (int i = 0; i < 100; i++) begin
      run(1);
      hi_a += {15'h0000, pwm_a === 1'b1};
      hi_b += {15'h0000, pwm_b === 1'b1};
      hi_s += 16'(strobe[0]) + 16'(strobe[1]) + 16'(strobe[2]);
    end
    check(hi_s, 16'h0003);
    check(hi_a, 16'h0028);
    check(hi_b, 16'h000A);
    check({8'h00, efine[0], efine[1]}, 16'h00C0);
    check({15'h0000, run_ph}, 16'h0001);
    hr_ctrl = '{1'b1, 1'b1, 2'h0, 1'b1};
    run(200);
    check({4'h0, efine[0], efine[1], efine[2]}, 16'h0F73);
    hr_ctrl = '{1'b1, 1'b1, 2'h0, 1'b0};
    run(200);
    check({3'h0, run_ph, efine[0], efine[1], efine[2]}, 16'h0000);
    // Divider: period of 10 cycles, settings 1 to 15
    period = 14'h0009;
    sample_trig = 14'h0004;
    for (int s = 1; s < 16; s++) begin
      div_setting = s[3:0];
      run(lim[s-1] * 20 + 20);
      window(lim[s-1] * 20);
      check(irq_n, 16'h0002);
      check(start_n, 16'h0002);
    end
    // Interrupt gated off, converter start still routed
    div_setting = 4'h1;
    int_enable = 1'b0;
    run(40);
    window(50);
    check(irq_n, 16'h0000);
    check(start_n, 16'h0005);
    // Freeze just after a start, then resume: next start after 9 enabled edges
    for (int i = 0; i < 20 && start !== 1'b1; i++) run(1);
    check({15'h0000, start}, 16'h0001);
    run(1);
    en = 1'b0;
    window(30);
    check(start_n, 16'h0000);
    en = 1'b1;
    window(9);
    check(start_n, 16'h0001);
    // Setting zero stops both
    div_setting = 4'h0;
    int_enable = 1'b1;
    run(40);
    window(50);
    check(irq_n | start_n, 16'h0000);
    end_of_test();
  end
endmodule
